// file: hw/cgu_pkg.sv
// cgu_pkg: constants and types for the clock generation unit
// assumes: single 40 MHz system clock, all inputs synchronous to it
package cgu_pkg;
  // oscillator source selection, fixed by flash configuration
  typedef enum logic [2:0] {
    CGU_SRC_XTAL_LOW = 3'b000,
    CGU_SRC_XTAL_MED = 3'b001,
    CGU_SRC_XTAL_HIGH = 3'b010,
    CGU_SRC_RC = 3'b011,
    CGU_SRC_WDOG = 3'b100,
    CGU_SRC_EXT = 3'b111
  } cgu_src_e;

  typedef enum logic [0:0] {
    CGU_PH_FIRST = 1'b0,
    CGU_PH_SECOND = 1'b1
  } cgu_phase_e;

  typedef struct packed {
    cgu_src_e src;
    logic rc_doubler;
    logic reset_pin_en;
  } cgu_cfg_s;

  typedef struct packed {
    logic rtc;
    logic capture;
    logic watchdog;
    logic timer1;
    logic timer0;
  } cgu_freeze_s;

  // extended register space, reached by data-pointer moves
  localparam logic [15:0] FREEZE_ADDR = 16'hffd0;
  localparam logic [7:0] FREEZE_RESET = 8'h00;
  localparam int FREEZE_RTC_BIT = 4;
  localparam int FREEZE_CCU_BIT = 3;
  localparam int FREEZE_WDT_BIT = 2;
  localparam int FREEZE_T1_BIT = 1;
  localparam int FREEZE_T0_BIT = 0;
  localparam int FREEZE_WIDTH = 5;

  // trim register bit layout
  localparam int TRIM_RC_BIT = 7;
  localparam int TRIM_CLKOUT_BIT = 6;
  localparam int TRIM_WIDTH = 6;
  localparam logic [5:0] TRIM_FACTORY = 6'h20;
  // aux control one bit for low power access
  localparam int AUX_LP_BIT = 7;

  localparam int DIV_MAX = 510;
  localparam int DIV_WIDTH = 8;
  localparam int MC_CPU_CLK = 2;

  // frequencies in kHz
  localparam int RC_NOM_KHZ = 7373;
  localparam int RC_DBL_KHZ = 14746;
  localparam int WDOG_KHZ = 400;
  localparam int XTAL_MIN_KHZ = 20;
  localparam int XTAL_LOW_MED_KHZ = 100;
  localparam int XTAL_MED_HIGH_KHZ = 4000;
  localparam int XTAL_MAX_KHZ = 18000;
  localparam int EXT_MIN_KHZ = 0;
  localparam int EXT_MAX_KHZ = 18000;
  localparam int RESET_PIN_KHZ = 12000;
  localparam int LP_MAX_KHZ = 8000;
endpackage

// file: hw/cgu_top.sv
// cgu_top: oscillator select, cpu clock divider, peripheral clock and freeze
// assumes: oscillator ticks arrive as one-cycle enables at 40 MHz sampling;
// sfr port from the core is synchronous; xdata port serves extended sfrs
// Operation
// - a machine cycle is two cpu clock periods; instructions take one or two.
// - peripheral clock runs at exactly half the cpu clock.
// - oscillator clock comes from exactly one of four configured sources.
// - crystal source has low, medium, high bands from 20 kHz to 18 MHz.
// - rc oscillator runs at 7.373 MHz, or 14.746 MHz with the doubler set.
// - a 6-bit trim field is loaded with a factory value and is rewritable.
// - clock out drives only if enabled, crystal unused and rtc not on crystal.
// - clock out runs at half the cpu clock.
// - low power access clears on any reset; software sets it at 8 MHz or less.
// - watchdog oscillator supplies 400 kHz when selected.
// - external clock enters on the crystal input; the output pin is port or clock.
// - extended registers sit in xdata space, reached by data-pointer moves.
// - cpu clock is oscillator clock divided by up to 510, changeable any time.
// - trim reloads only on power-on reset, not on other resets.
`timescale 1ns/1ps
module cgu_top #(
  parameter logic [5:0] TRIM_DEFAULT = cgu_pkg::TRIM_FACTORY
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic por_n,
  input wire cgu_pkg::cgu_cfg_s cfg,
  input wire logic xtal_tick,
  input wire logic ext_tick,
  input wire logic rc_tick,
  input wire logic wdog_tick,
  input wire logic rtc_on_xtal,
  input wire logic port_out,
  input wire logic sfr_trim_we,
  input wire logic sfr_aux_we,
  input wire logic sfr_div_we,
  input wire logic [7:0] sfr_wdata,
  input wire logic [15:0] xdata_addr,
  input wire logic xdata_wr,
  input wire logic xdata_rd,
  input wire logic [7:0] xdata_wdata,
  output logic [7:0] xdata_rdata,
  output logic xdata_hit,
  output logic [7:0] trim_rdata,
  output logic [7:0] aux_rdata,
  output logic [7:0] div_rdata,
  output logic osc_clk_a,
  output logic rc_clk_b,
  output logic cpu_clk,
  output logic machine_cycle,
  output logic periph_clk,
  output cgu_pkg::cgu_freeze_s periph_en,
  output logic crystal_out_pin,
  output logic crystal_out_oe,
  output logic low_power_access,
  output logic [5:0] rc_trim
);
  logic [5:0] trim_q;
  logic clkout_enable_q;
  logic rc_sel_q;
  logic low_power_access_q;
  logic [7:0] div_q;
  logic [8:0] cnt_q;
  logic cpu_tick_q;
  cgu_pkg::cgu_phase_e phase_q;
  logic pclk_q;
  logic [4:0] freeze_q;
  logic rc_half_q;

  // doubler off: rc source delivers every other tick
  wire rc_eff = cfg.rc_doubler ? rc_tick : (rc_tick & rc_half_q);
  wire osc_tick = (cfg.src == cgu_pkg::CGU_SRC_RC) ? rc_eff :
                  (cfg.src == cgu_pkg::CGU_SRC_WDOG) ? wdog_tick :
                  (cfg.src == cgu_pkg::CGU_SRC_EXT) ? ext_tick :
                  xtal_tick;
  wire xtal_used = (cfg.src == cgu_pkg::CGU_SRC_XTAL_LOW) |
                   (cfg.src == cgu_pkg::CGU_SRC_XTAL_MED) |
                   (cfg.src == cgu_pkg::CGU_SRC_XTAL_HIGH);
  // divide by 2*div, div 0 means undivided; reaches 510 at div 255
  wire [8:0] div_lim = (div_q == 8'h00) ? 9'h000 : {div_q, 1'b0} - 9'h001;
  wire cnt_wrap = osc_tick & (cnt_q >= div_lim);
  wire freeze_hit = (xdata_addr == cgu_pkg::FREEZE_ADDR);

  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      trim_q <= TRIM_DEFAULT;
    end else if (sfr_trim_we) begin
      trim_q <= sfr_wdata[cgu_pkg::TRIM_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      clkout_enable_q <= 1'b0;
      rc_sel_q <= 1'b0;
      low_power_access_q <= 1'b0;
      div_q <= 8'h00;
      freeze_q <= 5'h00;
    end else begin
      if (sfr_trim_we) begin
        clkout_enable_q <= sfr_wdata[cgu_pkg::TRIM_CLKOUT_BIT];
        rc_sel_q <= sfr_wdata[cgu_pkg::TRIM_RC_BIT];
      end
      if (sfr_aux_we) begin
        low_power_access_q <= sfr_wdata[cgu_pkg::AUX_LP_BIT];
      end
      if (sfr_div_we) begin
        div_q <= sfr_wdata;
      end
      if (xdata_wr && freeze_hit) begin
        freeze_q <= xdata_wdata[cgu_pkg::FREEZE_WIDTH-1:0];
      end
    end
  end

  // divider keeps counting across writes, so no glitch on change
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 9'h000;
      cpu_tick_q <= 1'b0;
      phase_q <= cgu_pkg::CGU_PH_FIRST;
      pclk_q <= 1'b0;
      rc_half_q <= 1'b0;
      osc_clk_a <= 1'b0;
    end else begin
      osc_clk_a <= osc_tick;
      if (rc_tick) begin
        rc_half_q <= ~rc_half_q;
      end
      cnt_q <= cnt_wrap ? 9'h000 : (osc_tick ? cnt_q + 9'h001 : cnt_q);
      cpu_tick_q <= cnt_wrap;
      if (cpu_tick_q) begin
        case (phase_q)
          cgu_pkg::CGU_PH_FIRST: phase_q <= cgu_pkg::CGU_PH_SECOND;
          cgu_pkg::CGU_PH_SECOND: phase_q <= cgu_pkg::CGU_PH_FIRST;
          default: phase_q <= cgu_pkg::CGU_PH_FIRST;
        endcase
        pclk_q <= ~pclk_q;
      end
    end
  end

  assign rc_clk_b = rc_eff;
  assign cpu_clk = cpu_tick_q;
  assign machine_cycle = cpu_tick_q & (phase_q == cgu_pkg::CGU_PH_SECOND);
  assign periph_clk = cpu_tick_q & pclk_q;
  assign periph_en.rtc = periph_clk & ~freeze_q[cgu_pkg::FREEZE_RTC_BIT];
  assign periph_en.capture = periph_clk & ~freeze_q[cgu_pkg::FREEZE_CCU_BIT];
  assign periph_en.watchdog = periph_clk & ~freeze_q[cgu_pkg::FREEZE_WDT_BIT];
  assign periph_en.timer1 = periph_clk & ~freeze_q[cgu_pkg::FREEZE_T1_BIT];
  assign periph_en.timer0 = periph_clk & ~freeze_q[cgu_pkg::FREEZE_T0_BIT];
  // level toggling per cpu tick gives half the cpu rate
  wire clkout_on = clkout_enable_q & ~xtal_used & ~rtc_on_xtal;
  assign crystal_out_pin = clkout_on ? pclk_q : port_out;
  assign crystal_out_oe = clkout_on | (cfg.src == cgu_pkg::CGU_SRC_EXT) |
                          (cfg.src == cgu_pkg::CGU_SRC_RC) |
                          (cfg.src == cgu_pkg::CGU_SRC_WDOG);
  assign low_power_access = low_power_access_q;
  assign rc_trim = trim_q;
  assign trim_rdata = {rc_sel_q, clkout_enable_q, trim_q};
  assign aux_rdata = {low_power_access_q, 7'h00};
  assign div_rdata = div_q;
  assign xdata_hit = freeze_hit & (xdata_rd | xdata_wr);
  assign xdata_rdata = (freeze_hit && xdata_rd) ? {3'h0, freeze_q} : 8'h00;

  property p_freeze_stops;
    @(posedge clock) disable iff (!resetn)
      freeze_q[cgu_pkg::FREEZE_T0_BIT] |-> !periph_en.timer0;
  endproperty
  a_freeze_stops: assert property (p_freeze_stops) else $error("frozen timer0 clocked");

  // what the previous cpu tick carried; reset to 1 so the first tick is a plain one
  logic pclk_seen_q;
  logic mc_seen_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pclk_seen_q <= 1'b1;
      mc_seen_q <= 1'b1;
    end else if (cpu_tick_q) begin
      pclk_seen_q <= periph_clk;
      mc_seen_q <= machine_cycle;
    end
  end

  property p_pclk_half;
    @(posedge clock) disable iff (!resetn)
      cpu_tick_q |-> periph_clk != pclk_seen_q;
  endproperty
  a_pclk_half: assert property (p_pclk_half) else $error("periph clock not cpu/2");

  property p_mc_two;
    @(posedge clock) disable iff (!resetn)
      cpu_tick_q |-> machine_cycle != mc_seen_q;
  endproperty
  a_mc_two: assert property (p_mc_two) else $error("machine cycle misplaced");

  property p_clkout_gate;
    @(posedge clock) disable iff (!resetn)
      (xtal_used || rtc_on_xtal || !clkout_enable_q) |-> crystal_out_pin == port_out;
  endproperty
  a_clkout_gate: assert property (p_clkout_gate) else $error("clock out while gated");

  property p_div_one;
    @(posedge clock) disable iff (!resetn)
      (div_q == 8'h00 && osc_tick && $stable(div_q)) |=> cpu_tick_q;
  endproperty
  a_div_one: assert property (p_div_one) else $error("undivided tick lost");

  property p_lp_write;
    @(posedge clock) disable iff (!resetn)
      sfr_aux_we |=> low_power_access == $past(sfr_wdata[7]);
  endproperty
  a_lp_write: assert property (p_lp_write) else $error("low power bit not written");

  property p_trim_write;
    @(posedge clock) disable iff (!por_n)
      sfr_trim_we |=> rc_trim == $past(sfr_wdata[5:0]);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim not written");

  property p_src_rc;
    @(posedge clock) disable iff (!resetn)
      (cfg.src == cgu_pkg::CGU_SRC_RC && cfg.rc_doubler) |-> osc_tick == rc_tick;
  endproperty
  a_src_rc: assert property (p_src_rc) else $error("rc source misselected");
endmodule

// file: verification/cgu_osc_model.sv
// cgu_osc_model: oscillator tick sources facing the clock unit
// assumes: ticks are one-cycle pulses sampled on the rising clock edge
`timescale 1ns/1ps
module cgu_osc_model (
  input wire logic clock,
  output logic xtal_tick,
  output logic ext_tick,
  output logic rc_tick,
  output logic wdog_tick
);
  logic [7:0] n_q = 8'h00;
  always_ff @(posedge clock) begin
    n_q <= n_q + 8'h01;
  end
  // distinct rates, so a wrong source shows up in the counts
  assign xtal_tick = (n_q % 3) == 0;
  assign ext_tick = (n_q % 5) == 1;
  assign rc_tick = n_q[0];
  assign wdog_tick = (n_q % 7) == 2;
endmodule

// file: verification/cgu_top_tb.sv
// cgu_top_tb: self-checking bench for the clock generation unit
// assumes: cgu_pkg compiled first; oscillator model supplies the ticks
`timescale 1ns/1ps
module cgu_top_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic por_n = 1'b0;
  cgu_pkg::cgu_cfg_s cfg = '0;
  logic xtal_tick, ext_tick, rc_tick, wdog_tick;
  logic rtc_on_xtal = 1'b0;
  logic port_out = 1'b0;
  logic sfr_trim_we = 1'b0, sfr_aux_we = 1'b0, sfr_div_we = 1'b0;
  logic [7:0] sfr_wdata = 8'h00, xdata_wdata = 8'h00;
  logic [15:0] xdata_addr = 16'h0000;
  logic xdata_wr = 1'b0, xdata_rd = 1'b0;
  logic [7:0] xdata_rdata, trim_rdata, aux_rdata, div_rdata;
  logic xdata_hit, osc_clk_a, rc_clk_b, cpu_clk, machine_cycle, periph_clk;
  cgu_pkg::cgu_freeze_s periph_en;
  logic crystal_out_pin, crystal_out_oe, low_power_access;
  logic [5:0] rc_trim;
  int n_errors = 0, n_tests = 0, cyc = 0;
  int c[13];
  logic [12:0] ev;
  logic clr = 1'b0, pin_q = 1'b0;
  logic [31:0] rs = 32'h0000_7390;
  logic [7:0] d, v;

  always #12.5 clock = ~clock;

  cgu_osc_model cgu_osc_model_inst (.clock, .xtal_tick, .ext_tick, .rc_tick, .wdog_tick);
  cgu_top cgu_top_inst (.clock, .resetn, .por_n, .cfg, .xtal_tick, .ext_tick, .rc_tick,
    .wdog_tick, .rtc_on_xtal, .port_out, .sfr_trim_we, .sfr_aux_we, .sfr_div_we, .sfr_wdata,
    .xdata_addr, .xdata_wr, .xdata_rd, .xdata_wdata, .xdata_rdata, .xdata_hit, .trim_rdata,
    .aux_rdata, .div_rdata, .osc_clk_a, .rc_clk_b, .cpu_clk, .machine_cycle, .periph_clk,
    .periph_en, .crystal_out_pin, .crystal_out_oe, .low_power_access, .rc_trim);

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic sel(cgu_pkg::cgu_src_e s);
    case (s)
      cgu_pkg::CGU_SRC_RC: return rc_tick;
      cgu_pkg::CGU_SRC_WDOG: return wdog_tick;
      cgu_pkg::CGU_SRC_EXT: return ext_tick;
      default: return xtal_tick;
    endcase
  endfunction

  function automatic bit near(int a, int b);
    return (a - b) <= 1 && (b - a) <= 1;
  endfunction

  task automatic report_and_stop();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // counting on the falling edge keeps clear of the design's updates
  always @(negedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
    ev = {periph_en, rc_tick, crystal_out_pin & ~pin_q, periph_clk, machine_cycle, cpu_clk,
      rc_clk_b, sel(cfg.src), osc_clk_a};
    pin_q = crystal_out_pin;
    if (clr) c = '{default: 0};
    else for (int i = 0; i < 13; i++) c[i] += ev[i];
  end

  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic rst(input logic por, input cgu_pkg::cgu_src_e s, input logic dbl);
    @(posedge clock);
    #2;
    resetn = 1'b0;
    por_n = !por;
    cfg = '{s, dbl, 1'((s == cgu_pkg::CGU_SRC_XTAL_HIGH || s == cgu_pkg::CGU_SRC_EXT) | (xs() % 2))};
    repeat (20) @(posedge clock);
    #2;
    resetn = 1'b1;
    por_n = 1'b1;
  endtask

  task automatic wr(input int k, input logic [15:0] a, input logic [7:0] w);
    @(posedge clock);
    #2;
    {sfr_trim_we, sfr_aux_we, sfr_div_we, xdata_wr} = 4'h8 >> k;
    sfr_wdata = w;
    xdata_wdata = w;
    xdata_addr = a;
    port_out = xs() % 2;
    @(posedge clock);
    #2;
    {sfr_trim_we, sfr_aux_we, sfr_div_we, xdata_wr} = 4'h0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
    @(posedge clock);
    #2;
    xdata_addr = a;
    xdata_rd = 1'b1;
    #5;
    chk(xdata_rdata === e && xdata_hit === h, "xdata read");
    @(posedge clock);
    #2;
    xdata_rd = 1'b0;
  endtask

  task automatic win(input int n);
    @(posedge clock);
    clr = 1'b1;
    @(posedge clock);
    clr = 1'b0;
    repeat (n) @(posedge clock);
  endtask

  initial begin
    rst(1'b1, cgu_pkg::CGU_SRC_RC, 1'b1);
    chk(rc_trim === cgu_pkg::TRIM_FACTORY && trim_rdata[6] === 1'b0, "trim reset");
    chk(low_power_access === 1'b0 && aux_rdata === 8'h00, "low power reset");
    rd(cgu_pkg::FREEZE_ADDR, cgu_pkg::FREEZE_RESET, 1'b1);
    for (int i = 0; i < 8; i++) begin
      if (i < 5 || i == 7) begin
        rst(1'b0, cgu_pkg::cgu_src_e'(i[2:0]), i[0]);
        win(210);
        chk(near(c[0], (i == 3 && !i[0]) ? c[1] / 2 : c[1]), "source rate");
        chk(near(c[2], i[0] ? c[7] : c[7] / 2), "rc doubler rate");
      end
    end
    rst(1'b0, cgu_pkg::CGU_SRC_RC, 1'b1);
    for (int k = 0; k < 4; k++) begin
      d = (k == 3) ? 8'((xs() % 6) + 2) : 8'(k);
      v = {2'b01, 6'(xs())};
      wr(2, 16'h0000, d);
      wr(0, 16'h0000, v);
      win(420);
      chk(div_rdata === d && rc_trim === v[5:0] && trim_rdata === v, "divider or trim write");
      chk(near(c[3], d == 0 ? c[0] : c[0] / (2 * d)), "cpu clock rate");
      chk(near(c[4], c[3] / 2) && near(c[5], c[3] / 2), "machine and periph");
      chk(crystal_out_oe === 1'b1 && near(c[6], c[3] / 2), "clock out rate");
    end
    #2;
    rtc_on_xtal = 1'b1;
    #5;
    chk(crystal_out_oe === 1'b1 && crystal_out_pin === port_out, "rtc on crystal");
    rtc_on_xtal = 1'b0;
    wr(1, 16'h0000, 8'h80);
    chk(low_power_access === 1'b1, "low power set");
    rst(1'b0, cgu_pkg::CGU_SRC_XTAL_HIGH, 1'b0);
    chk(low_power_access === 1'b0 && rc_trim === v[5:0], "warm reset");
    wr(0, 16'h0000, 8'h40);
    chk(crystal_out_oe === 1'b0 && crystal_out_pin === port_out, "crystal in use");
    rst(1'b1, cgu_pkg::CGU_SRC_RC, 1'b1);
    chk(rc_trim === cgu_pkg::TRIM_FACTORY, "power-on trim reload");
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 8'h1f : (k == 5) ? 8'h00 : 8'(xs() % 32);
      wr(3, cgu_pkg::FREEZE_ADDR, v);
      wr(3, 16'hffd1, 8'h1f);
      rd(cgu_pkg::FREEZE_ADDR, v, 1'b1);
      rd(16'hffd1, 8'h00, 1'b0);
      win(120);
      for (int b = 0; b < 5; b++) begin
        chk(v[b] ? c[8 + b] == 0 : near(c[8 + b], c[5]), "freeze gating");
      end
    end
    report_and_stop();
  end
endmodule
